// >>> core/half_bridge_pwm_control.sv
// Control logic of a multi-output half-bridge driver: mode, reset, PWM channels, gate drive.
// Assumes reset is the logic-supply power-on/undervoltage reset; pins arrive asynchronously.
//
// Added by the designer: strobed register access and the address map.

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Power-on clears all settings, outputs off
// - Load-supply loss keeps settings, outputs off
// - Enable high: normal mode, registers writable
// - Enable low: sleep, outputs off, registers cleared
// - Enable reads low until driven high
// - Logic undervoltage: no access, cleared, outputs off
// - Reset indicator reads zero after any reset
// - Bridges driven continuously or by PWM
// - Three channels, each with 8-bit duty
// - Rate codes select 80, 100, 200 Hz
// - Fast bit runs channel at 2 kHz
// - Rate code 00 stops the channel unless its fast bit is set
// - Nonzero rate starts the PWM period
// - Live changes applied glitch-free at period end
// - Optional active free-wheeling in off phase
// - Dead time between high and low side
// - Stopped channel with free-wheel: low side on
// - No channel, no activation: bridge tri-stated
// - Fault pin low on any protection fault
// - Overcurrent latches switch off until cleared
module half_bridge_pwm_control
  import hb_pwm_pkg::*;
#(
  parameter int N_BRIDGES = 12,
  parameter int DEAD_CYCLES = DEAD_CYC_DEF
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic enable_pin,
  input wire logic load_supply_ok,
  input wire logic [N_BRIDGES-1:0] oc_high_side,
  input wire logic [N_BRIDGES-1:0] oc_low_side,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [N_BRIDGES-1:0] high_side_gate,
  output logic [N_BRIDGES-1:0] low_side_gate,
  output logic fault_alert_low
);

  localparam int SYNC_W = 2 + 2 * N_BRIDGES;

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] off);
    return wr && (addr == off);
  endfunction

  function automatic logic [7:0] duty_offset(input int ch);
    return 8'(OFF_DUTY_BASE + OFF_DUTY_STRIDE * ch);
  endfunction

  // Clock cycles per duty step for a channel setting
  function automatic logic [PRESC_W-1:0] step_len(input channel_cfg_t cfg);
    logic [PRESC_W-1:0] len;
    len = PRESC_W'(STEP_CYC_80);
    if (cfg.fast) begin
      len = PRESC_W'(STEP_CYC_FAST);
    end else begin
      unique case (cfg.rate)
        RATE_80: len = PRESC_W'(STEP_CYC_80);
        RATE_100: len = PRESC_W'(STEP_CYC_100);
        RATE_200: len = PRESC_W'(STEP_CYC_200);
        RATE_STOP: len = PRESC_W'(STEP_CYC_80);
      endcase
    end
    return len;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [SYNC_W-1:0] pin_meta_r;
  logic [SYNC_W-1:0] pin_sync_r;

  // Zero reset value keeps an undriven enable in sleep
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= {oc_low_side, oc_high_side, load_supply_ok, enable_pin};
      pin_sync_r <= pin_meta_r;
    end
  end

  logic sleep;
  logic load_ok;
  logic [N_BRIDGES-1:0] oc_hs_sync;
  logic [N_BRIDGES-1:0] oc_ls_sync;
  assign sleep = ~pin_sync_r[0];
  assign load_ok = pin_sync_r[1];
  assign oc_hs_sync = pin_sync_r[2 +: N_BRIDGES];
  assign oc_ls_sync = pin_sync_r[2 + N_BRIDGES +: N_BRIDGES];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [2*N_BRIDGES-1:0] bridge_activation_r;
  logic [2*N_BRIDGES-1:0] bridge_channel_select_r;
  logic [N_BRIDGES-1:0] freewheel_r;
  logic [DUTY_W-1:0] duty_cycle_r [NUM_CHANNELS];
  logic [2*NUM_CHANNELS-1:0] channel_rate_r;
  logic [NUM_CHANNELS-1:0] fast_rate_r;
  logic reset_indicator_r;

  // Reset and sleep both return every setting to zero; writes only land in normal mode
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bridge_activation_r <= '0;
      bridge_channel_select_r <= '0;
      freewheel_r <= '0;
    end else if (sleep) begin
      bridge_activation_r <= '0;
      bridge_channel_select_r <= '0;
      freewheel_r <= '0;
    end else begin
      if (wr_hit(reg_wr, reg_addr, OFF_BRIDGE_ACT)) begin
        bridge_activation_r <= reg_wdata[2*N_BRIDGES-1:0];
      end
      if (wr_hit(reg_wr, reg_addr, OFF_BRIDGE_CHSEL)) begin
        bridge_channel_select_r <= reg_wdata[2*N_BRIDGES-1:0];
      end
      if (wr_hit(reg_wr, reg_addr, OFF_FREEWHEEL)) begin
        freewheel_r <= reg_wdata[N_BRIDGES-1:0];
      end
    end
  end

  // Channel rate settings
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      channel_rate_r <= '0;
      fast_rate_r <= '0;
    end else if (sleep) begin
      channel_rate_r <= '0;
      fast_rate_r <= '0;
    end else begin
      if (wr_hit(reg_wr, reg_addr, OFF_CHANNEL_RATE)) begin
        channel_rate_r <= reg_wdata[2*NUM_CHANNELS-1:0];
      end
      if (wr_hit(reg_wr, reg_addr, OFF_FAST_RATE)) begin
        fast_rate_r <= reg_wdata[NUM_CHANNELS-1:0];
      end
    end
  end

  // Duty cycle of each channel
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int c = 0; c < NUM_CHANNELS; c++) begin
        duty_cycle_r[c] <= '0;
      end
    end else if (sleep) begin
      for (int c = 0; c < NUM_CHANNELS; c++) begin
        duty_cycle_r[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_CHANNELS; c++) begin
        if (wr_hit(reg_wr, reg_addr, duty_offset(c))) begin
          duty_cycle_r[c] <= reg_wdata[DUTY_W-1:0];
        end
      end
    end
  end

  // Host writes 1 to acknowledge; any reset brings it back to 0
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reset_indicator_r <= 1'b0;
    end else if (sleep) begin
      reset_indicator_r <= 1'b0;
    end else if (wr_hit(reg_wr, reg_addr, OFF_GLOBAL_STATUS) && reg_wdata[GS_RESET_IND_BIT]) begin
      reset_indicator_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overcurrent latches: write 1 to clear, a new event wins over the clear
  logic [N_BRIDGES-1:0] oc_hs_r;
  logic [N_BRIDGES-1:0] oc_ls_r;
  logic [N_BRIDGES-1:0] oc_hs_clr;
  logic [N_BRIDGES-1:0] oc_ls_clr;

  assign oc_hs_clr = wr_hit(reg_wr, reg_addr, OFF_OC_HIGH) ? reg_wdata[N_BRIDGES-1:0] : '0;
  assign oc_ls_clr = wr_hit(reg_wr, reg_addr, OFF_OC_LOW) ? reg_wdata[N_BRIDGES-1:0] : '0;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      oc_hs_r <= '0;
      oc_ls_r <= '0;
    end else if (sleep) begin
      oc_hs_r <= '0;
      oc_ls_r <= '0;
    end else begin
      oc_hs_r <= (oc_hs_r & ~oc_hs_clr) | oc_hs_sync;
      oc_ls_r <= (oc_ls_r & ~oc_ls_clr) | oc_ls_sync;
    end
  end

  logic load_error;
  logic supply_error;
  assign load_error = |{oc_hs_r, oc_ls_r};
  assign supply_error = ~load_ok & ~sleep;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      fault_alert_low <= 1'b1;
    end else begin
      fault_alert_low <= ~(load_error | supply_error);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM channels
  logic [NUM_CHANNELS-1:0] pwm_phase;
  logic [NUM_CHANNELS-1:0] pwm_running;

  for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan
    channel_cfg_t live_cfg;
    channel_cfg_t shadow_r;
    logic [PRESC_W-1:0] presc_r;
    logic [DUTY_W-1:0] step_r;
    logic running_r;
    logic live_run;

    assign live_cfg = '{fast: fast_rate_r[c], rate: channel_rate_r[2*c +: 2], duty: duty_cycle_r[c]};
    assign live_run = live_cfg.fast | (live_cfg.rate != RATE_STOP);

    always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
        shadow_r <= '0;
        presc_r <= '0;
        step_r <= '0;
        running_r <= 1'b0;
      end else if (!live_run) begin
        running_r <= 1'b0;
        presc_r <= '0;
        step_r <= '0;
        shadow_r <= live_cfg;
      end else if (!running_r) begin
        running_r <= 1'b1;
        presc_r <= '0;
        step_r <= '0;
        shadow_r <= live_cfg;
      end else if (presc_r == step_len(shadow_r) - PRESC_W'(1)) begin
        presc_r <= '0;
        step_r <= step_r + DUTY_W'(1);
        if (step_r == {DUTY_W{1'b1}}) begin
          shadow_r <= live_cfg;
        end
      end else begin
        presc_r <= presc_r + PRESC_W'(1);
      end
    end

    assign pwm_running[c] = running_r;
    assign pwm_phase[c] = running_r && (step_r < shadow_r.duty);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate drive per half-bridge
  for (genvar b = 0; b < N_BRIDGES; b++) begin : g_bridge
    switch_pair_t want;
    logic [1:0] sel;
    logic hs_en;
    logic ls_en;
    logic on_phase;
    logic hs_r;
    logic ls_r;
    logic [DEAD_W-1:0] dead_r;
    logic dead_done;

    assign sel = bridge_channel_select_r[2*b +: 2];
    assign hs_en = bridge_activation_r[2*b + ACT_HS_POS];
    assign ls_en = bridge_activation_r[2*b + ACT_LS_POS];
    assign on_phase = (sel == CH_NONE) ? 1'b0 : pwm_phase[2'(sel - 2'h1)];

    always_comb begin
      want = '0;
      if (hs_en && ls_en) begin
        want = '0;
      end else if (sel == CH_NONE) begin
        want.hs = hs_en;
        want.ls = ls_en;
      end else if (on_phase) begin
        want.hs = hs_en;
        want.ls = ls_en;
      end else if (freewheel_r[b]) begin
        want.hs = ls_en;
        want.ls = hs_en;
      end
      if (sleep || !load_ok) begin
        want = '0;
      end
      if (oc_hs_r[b]) begin
        want.hs = 1'b0;
      end
      if (oc_ls_r[b]) begin
        want.ls = 1'b0;
      end
    end

    assign dead_done = (dead_r >= DEAD_W'(DEAD_CYCLES));

    // A side turns on only after both have been off for the dead time; short pulses vanish
    always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
        hs_r <= 1'b0;
        ls_r <= 1'b0;
      end else begin
        hs_r <= want.hs & (hs_r | (~ls_r & dead_done));
        ls_r <= want.ls & (ls_r | (~hs_r & dead_done));
      end
    end

    // Counts cycles with both sides off, saturating at the dead time
    always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
        dead_r <= '0;
      end else if (hs_r || ls_r) begin
        dead_r <= '0;
      end else if (!dead_done) begin
        dead_r <= dead_r + DEAD_W'(1);
      end
    end

    assign high_side_gate[b] = hs_r;
    assign low_side_gate[b] = ls_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= REG_RESET_VAL;
    end else if (reg_rd) begin
      reg_rdata <= REG_RESET_VAL;
      if (reg_addr == OFF_GLOBAL_STATUS) begin
        reg_rdata[GS_RESET_IND_BIT] <= reset_indicator_r;
        reg_rdata[GS_LOAD_ERR_BIT] <= load_error;
        reg_rdata[GS_SUPPLY_ERR_BIT] <= supply_error;
      end else if (reg_addr == OFF_BRIDGE_ACT) begin
        reg_rdata <= 32'(bridge_activation_r);
      end else if (reg_addr == OFF_BRIDGE_CHSEL) begin
        reg_rdata <= 32'(bridge_channel_select_r);
      end else if (reg_addr == OFF_FREEWHEEL) begin
        reg_rdata <= 32'(freewheel_r);
      end else if (reg_addr == OFF_CHANNEL_RATE) begin
        reg_rdata <= 32'(channel_rate_r);
      end else if (reg_addr == OFF_FAST_RATE) begin
        reg_rdata <= 32'(fast_rate_r);
      end else if (reg_addr == OFF_OC_HIGH) begin
        reg_rdata <= 32'(oc_hs_r);
      end else if (reg_addr == OFF_OC_LOW) begin
        reg_rdata <= 32'(oc_ls_r);
      end else begin
        for (int c = 0; c < NUM_CHANNELS; c++) begin
          if (reg_addr == duty_offset(c)) begin
            reg_rdata <= 32'(duty_cycle_r[c]);
          end
        end
      end
    end
  end

endmodule // half_bridge_pwm_control

// >>> common/hb_pwm_pkg.sv
// Constants, field codes and carrier types of the half-bridge PWM control block.
// Assumes a 50 MHz system clock and a 32-bit plain register port with byte addresses.
package hb_pwm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int DUTY_STEPS = 256;
  localparam int RATE_80_HZ = 80;
  localparam int RATE_100_HZ = 100;
  localparam int RATE_200_HZ = 200;
  localparam int RATE_FAST_HZ = 2000;
  localparam int STEP_CYC_80 = CLK_HZ / (RATE_80_HZ * DUTY_STEPS);
  localparam int STEP_CYC_100 = CLK_HZ / (RATE_100_HZ * DUTY_STEPS);
  localparam int STEP_CYC_200 = CLK_HZ / (RATE_200_HZ * DUTY_STEPS);
  localparam int STEP_CYC_FAST = CLK_HZ / (RATE_FAST_HZ * DUTY_STEPS);
  localparam int PRESC_W = 12;
  localparam int DEAD_TIME_NS = 500;
  localparam int DEAD_CYC_DEF = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Channel and rate codes
  localparam int NUM_CHANNELS = 3;
  localparam int DUTY_W = 8;
  localparam logic [1:0] RATE_STOP = 2'h0;
  localparam logic [1:0] RATE_80 = 2'h1;
  localparam logic [1:0] RATE_100 = 2'h2;
  localparam logic [1:0] RATE_200 = 2'h3;
  localparam logic [1:0] CH_NONE = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [7:0] OFF_GLOBAL_STATUS = 8'h00;
  localparam logic [7:0] OFF_BRIDGE_ACT = 8'h04;
  localparam logic [7:0] OFF_BRIDGE_CHSEL = 8'h08;
  localparam logic [7:0] OFF_FREEWHEEL = 8'h0c;
  localparam logic [7:0] OFF_DUTY_BASE = 8'h10;
  localparam logic [7:0] OFF_DUTY_STRIDE = 8'h04;
  localparam logic [7:0] OFF_CHANNEL_RATE = 8'h1c;
  localparam logic [7:0] OFF_FAST_RATE = 8'h20;
  localparam logic [7:0] OFF_OC_HIGH = 8'h24;
  localparam logic [7:0] OFF_OC_LOW = 8'h28;

  // Global status fields
  localparam int GS_RESET_IND_BIT = 0;
  localparam int GS_LOAD_ERR_BIT = 1;
  localparam int GS_SUPPLY_ERR_BIT = 2;

  // Field layout inside the bridge activation register
  localparam int ACT_HS_POS = 0;
  localparam int ACT_LS_POS = 1;

  localparam logic [31:0] REG_RESET_VAL = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic fast;
    logic [1:0] rate;
    logic [DUTY_W-1:0] duty;
  } channel_cfg_t;

  typedef struct packed {
    logic hs;
    logic ls;
  } switch_pair_t;

endpackage

// >>> test/hb_pwm_chk.sv
// Checker for the half-bridge PWM control block.
// Sees only the top ports; bound into every instance of the block.
module hb_pwm_chk
  import hb_pwm_pkg::*;
#(
  parameter int N_BRIDGES = 12,
  parameter int DEAD_CYCLES = 25
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic enable_pin,
  input wire logic load_supply_ok,
  input wire logic [N_BRIDGES-1:0] oc_high_side,
  input wire logic [N_BRIDGES-1:0] oc_low_side,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [N_BRIDGES-1:0] high_side_gate,
  input wire logic [N_BRIDGES-1:0] low_side_gate,
  input wire logic fault_alert_low
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // Consecutive cycles with both switches of bridge 0 off
  logic [7:0] off_cnt_r;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset)
      off_cnt_r <= 8'hff;
    else if (high_side_gate[0] | low_side_gate[0])
      off_cnt_r <= 8'h00;
    else if (off_cnt_r != 8'hff)
      off_cnt_r <= off_cnt_r + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_no_cross;
    (high_side_gate & low_side_gate) == '0;
  endproperty
  a_no_cross: assert property (p_no_cross)
    else $error("both switches of a bridge on");
  property p_dead;
    ($rose(high_side_gate[0]) || $rose(low_side_gate[0])) |-> off_cnt_r >= DEAD_CYCLES;
  endproperty
  a_dead: assert property (p_dead)
    else $error("turn-on without dead time");
  property p_sleep;
    (!enable_pin) [*4] |=> (high_side_gate == '0) && (low_side_gate == '0);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("gate on in sleep");
  property p_rd_sleep;
    (!enable_pin) [*4] ##0 reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rd_sleep: assert property (p_rd_sleep)
    else $error("nonzero read in sleep");
  property p_load;
    (!load_supply_ok) [*4] |=> (high_side_gate == '0) && (low_side_gate == '0);
  endproperty
  a_load: assert property (p_load)
    else $error("gate on without load supply");
  property p_reset_vals;
    $fell(reset) |-> high_side_gate == '0 && low_side_gate == '0 && fault_alert_low;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("outputs not cleared by reset");
  property p_oc;
    (oc_high_side[0] && enable_pin) [*6] |=> !high_side_gate[0] && !fault_alert_low;
  endproperty
  a_oc: assert property (p_oc)
    else $error("overcurrent not latched off");
  property p_fault_supply;
    (enable_pin && !load_supply_ok) [*5] |=> !fault_alert_low;
  endproperty
  a_fault_supply: assert property (p_fault_supply)
    else $error("fault pin not low on supply error");
endmodule // hb_pwm_chk

bind half_bridge_pwm_control hb_pwm_chk #(.N_BRIDGES(N_BRIDGES), .DEAD_CYCLES(DEAD_CYCLES)) u_hb_pwm_chk (
  .sys_clk(sys_clk), .reset(reset), .enable_pin(enable_pin), .load_supply_ok(load_supply_ok),
  .oc_high_side(oc_high_side), .oc_low_side(oc_low_side), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .high_side_gate(high_side_gate),
  .low_side_gate(low_side_gate), .fault_alert_low(fault_alert_low));

// >>> test/hb_host.sv
// Host model: register master on the plain port.
// Assumes tasks are entered just after a rising clock edge.
module hb_host
  import hb_pwm_pkg::*;
(
  input wire logic sys_clk,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Extra edge at the end keeps back-to-back calls from double assignment
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    v = reg_rdata;
    @(posedge sys_clk);
  endtask
  // Bridge 0 on channel 1: stop, assign, duty, rate, activate
  task automatic prog(input logic [7:0] duty, input logic [1:0] rate, input logic fast, input logic [31:0] act);
    wr(OFF_CHANNEL_RATE, 32'h0);
    wr(OFF_BRIDGE_CHSEL, 32'h1);
    wr(OFF_DUTY_BASE, {24'h0, duty});
    wr(OFF_FAST_RATE, {31'h0, fast});
    wr(OFF_CHANNEL_RATE, {30'h0, rate});
    wr(OFF_BRIDGE_ACT, act);
  endtask
endmodule // hb_host

// >>> test/half_bridge_pwm_control_tb.sv
// Self-checking bench of the half-bridge PWM control block.
// Assumes the host model drives the register port; four bridges, short dead time.
module half_bridge_pwm_control_tb;
  import hb_pwm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NB = 4;
  localparam int FULL = 255 * STEP_CYC_FAST;
  logic sys_clk, reset, enable_pin, load_supply_ok, reg_wr, reg_rd, fault_alert_low;
  logic [NB-1:0] oc_high_side, oc_low_side, high_side_gate, low_side_gate;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  int mismatches = 0;
  int checks_done = 0;
  int steps [4] = '{STEP_CYC_80, STEP_CYC_100, STEP_CYC_200, STEP_CYC_FAST};

  half_bridge_pwm_control #(.N_BRIDGES(NB), .DEAD_CYCLES(2)) u_half_bridge_pwm_control (
    .sys_clk(sys_clk), .reset(reset), .enable_pin(enable_pin), .load_supply_ok(load_supply_ok),
    .oc_high_side(oc_high_side), .oc_low_side(oc_low_side), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .high_side_gate(high_side_gate),
    .low_side_gate(low_side_gate), .fault_alert_low(fault_alert_low));
  hb_host u_hb_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  always #10 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic gates(input logic [3:0] h, input logic [3:0] l, input logic f);
    @(negedge sys_clk);
    chk(32'(high_side_gate), 32'(h));
    chk(32'(low_side_gate), 32'(l));
    chk(32'(fault_alert_low), 32'(f));
    @(posedge sys_clk);
  endtask
  // Cycles low before, then high, of the next pulse on high side 0
  task automatic pulse(output int lo, output int hi);
    lo = 0;
    hi = 0;
    while (high_side_gate[0] !== 1'b1 && lo < 30000) begin
      @(negedge sys_clk);
      lo++;
    end
    while (high_side_gate[0] === 1'b1 && hi < 70000) begin
      @(negedge sys_clk);
      hi++;
    end
    @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_start;
    u_hb_host.rd(OFF_GLOBAL_STATUS, d);
    chk(d, 32'h0);
    u_hb_host.rd(OFF_BRIDGE_ACT, d);
    chk(d, 32'h0);
    u_hb_host.wr(OFF_GLOBAL_STATUS, 32'h1);
    u_hb_host.rd(OFF_GLOBAL_STATUS, d);
    chk(d & 32'h1, 32'h1);
    u_hb_host.wr(8'h40, 32'hffff_ffff);
    u_hb_host.rd(8'h40, d);
    chk(d, 32'h0);
    $display("start done");
  endtask
  task automatic t_cont;
    u_hb_host.wr(OFF_BRIDGE_ACT, 32'h39);
    repeat (8) @(posedge sys_clk);
    gates(4'h1, 4'h2, 1'b1);
    load_supply_ok <= 1'b0;
    repeat (8) @(posedge sys_clk);
    gates(4'h0, 4'h0, 1'b0);
    u_hb_host.rd(OFF_GLOBAL_STATUS, d);
    chk(d & 32'h4, 32'h4);
    load_supply_ok <= 1'b1;
    repeat (8) @(posedge sys_clk);
    gates(4'h1, 4'h2, 1'b1);
    oc_high_side <= 4'h1;
    repeat (8) @(posedge sys_clk);
    gates(4'h0, 4'h2, 1'b0);
    u_hb_host.rd(OFF_OC_HIGH, d);
    chk(d, 32'h1);
    u_hb_host.rd(OFF_BRIDGE_ACT, d);
    chk(d, 32'h39);
    u_hb_host.rd(OFF_GLOBAL_STATUS, d);
    chk(d & 32'h2, 32'h2);
    oc_high_side <= 4'h0;
    repeat (4) @(posedge sys_clk);
    u_hb_host.wr(OFF_OC_HIGH, 32'h1);
    repeat (8) @(posedge sys_clk);
    gates(4'h1, 4'h2, 1'b1);
    oc_low_side <= 4'h2;
    repeat (8) @(posedge sys_clk);
    gates(4'h1, 4'h0, 1'b0);
    oc_low_side <= 4'h0;
    repeat (4) @(posedge sys_clk);
    u_hb_host.wr(OFF_OC_LOW, 32'h2);
    repeat (8) @(posedge sys_clk);
    gates(4'h1, 4'h2, 1'b1);
    u_hb_host.wr(OFF_BRIDGE_ACT, 32'h0);
    repeat (8) @(posedge sys_clk);
    gates(4'h0, 4'h0, 1'b1);
    $display("continuous done");
  endtask
  task automatic t_rates;
    int lo, hi;
    for (int r = 0; r < 4; r++) begin
      u_hb_host.prog(8'h01, (r < 3) ? 2'(r + 1) : 2'h0, r == 3, 32'h1);
      pulse(lo, hi);
      chk_rng(hi, steps[r] - 12, steps[r] + 2);
    end
    u_hb_host.wr(OFF_DUTY_BASE, 32'hff);
    pulse(lo, hi);
    chk_rng(lo, FULL - 60, FULL + 4);
    chk_rng(hi, FULL - 4, FULL + 4);
    u_hb_host.prog(8'hff, 2'h0, 1'b0, 32'h1);
    repeat (20) @(posedge sys_clk);
    gates(4'h0, 4'h0, 1'b1);
    u_hb_host.wr(OFF_CHANNEL_RATE, 32'h3);
    repeat (10) @(posedge sys_clk);
    gates(4'h1, 4'h0, 1'b1);
    u_hb_host.wr(OFF_CHANNEL_RATE, 32'h0);
    u_hb_host.wr(OFF_FREEWHEEL, 32'h1);
    repeat (10) @(posedge sys_clk);
    gates(4'h0, 4'h1, 1'b1);
    u_hb_host.wr(OFF_DUTY_BASE + OFF_DUTY_STRIDE, 32'h5a);
    u_hb_host.rd(OFF_DUTY_BASE + OFF_DUTY_STRIDE, d);
    chk(d, 32'h5a);
    u_hb_host.wr(8'(OFF_DUTY_BASE + 2 * OFF_DUTY_STRIDE), 32'hff);
    u_hb_host.wr(OFF_BRIDGE_CHSEL, 32'hd);
    u_hb_host.wr(OFF_CHANNEL_RATE, 32'h30);
    u_hb_host.wr(OFF_BRIDGE_ACT, 32'h5);
    repeat (10) @(posedge sys_clk);
    gates(4'h2, 4'h1, 1'b1);
    $display("rates done");
  endtask
  task automatic t_sleep;
    enable_pin <= 1'b0;
    repeat (10) @(posedge sys_clk);
    gates(4'h0, 4'h0, 1'b1);
    u_hb_host.rd(OFF_BRIDGE_ACT, d);
    chk(d, 32'h0);
    u_hb_host.wr(OFF_BRIDGE_ACT, 32'h1);
    enable_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    u_hb_host.rd(OFF_BRIDGE_ACT, d);
    chk(d, 32'h0);
    u_hb_host.rd(OFF_GLOBAL_STATUS, d);
    chk(d, 32'h0);
    $display("sleep done");
  endtask
  task automatic t_rereset;
    u_hb_host.wr(OFF_GLOBAL_STATUS, 32'h1);
    u_hb_host.wr(OFF_BRIDGE_CHSEL, 32'h2);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    u_hb_host.rd(OFF_GLOBAL_STATUS, d);
    chk(d, 32'h0);
    u_hb_host.rd(OFF_BRIDGE_CHSEL, d);
    chk(d, 32'h0);
    gates(4'h0, 4'h0, 1'b1);
    $display("second reset done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    enable_pin = 1'b0;
    load_supply_ok = 1'b1;
    oc_high_side = 4'h0;
    oc_low_side = 4'h0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    enable_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_start;
    t_cont;
    t_rates;
    t_sleep;
    t_rereset;
    give_verdict;
  end
  // Tests need about 60k cycles
  initial begin
    repeat (90000) @(posedge sys_clk);
    mismatches++;
    give_verdict;
  end
endmodule // half_bridge_pwm_control_tb
